// >>> inc/lsb_defines.vh
// constants for the logical signal bank: register offsets, fields, timing
`ifndef LSB_DEFINES_VH
`define LSB_DEFINES_VH

// register offsets (byte addresses on the plain register port)
`define LSB_ADDR_OUT_STATE   8'h00
`define LSB_ADDR_IN_STATE    8'h04
`define LSB_ADDR_IN_MODE     8'h08
`define LSB_ADDR_CMD_SET     8'h0c
`define LSB_ADDR_CMD_CLR     8'h10
`define LSB_ADDR_EV_ON_SEL   8'h14
`define LSB_ADDR_EV_OFF_SEL  8'h18
`define LSB_ADDR_IRQ_STAT    8'h1c
`define LSB_ADDR_IRQ_MASK    8'h20
`define LSB_ADDR_TIME_LO     8'h24
`define LSB_ADDR_EV_DATA     8'h28
`define LSB_ADDR_EV_TIME     8'h2c

// reset values
`define LSB_RST_ZERO         32'h0000_0000
`define LSB_RST_EV_SEL       32'hffff_ffff

// interrupt status bits
`define LSB_IRQ_EVENT_BIT    0
`define LSB_IRQ_OVERRUN_BIT  1

// event word layout: bit 5 = on(1)/off(0), bits 4:0 = output index
`define LSB_EV_KIND_BIT      5

// timing
`define LSB_CLK_HZ           20000000
`define LSB_TICK_US          1
`define LSB_PULSE_US         5000
`define LSB_PRESCALE         ((`LSB_CLK_HZ / 1000000) * `LSB_TICK_US)
`define LSB_PULSE_TICKS      (`LSB_PULSE_US / `LSB_TICK_US)

`endif

// >>> hdl/lsb_prescaler.v
// prescaler: one-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
module lsb_prescaler #(
  parameter DIV = 20
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // tick output
  output reg         tick
);
  reg [15:0] cnt_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
    end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick    <= 1'b0;
    end
  end
endmodule // lsb_prescaler

// >>> hdl/lsb_pulse_timer.v
// per-input pulse timer: counts ticks down while a pulse is active
`timescale 1ns/1ps
module lsb_pulse_timer #(
  parameter TICKS = 5000
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control
  input  wire        start,
  input  wire        tick,
  output reg         expire
);
  reg [12:0] cnt_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 13'h0000;
      expire  <= 1'b0;
    end else if (start) begin
      // a repeated command restarts the full length
      cnt_reg <= TICKS[12:0];
      expire  <= 1'b0;
    end else if (tick && cnt_reg != 13'h0000) begin
      cnt_reg <= cnt_reg - 13'h0001;
      expire  <= (cnt_reg == 13'h0001);
    end else begin
      expire  <= 1'b0;
    end
  end
endmodule // lsb_pulse_timer

// >>> hdl/lsb_bank.v
// logical signal bank: 32 logic outputs with events, 32 command-driven inputs
// Functional notes
// [R01] thirty-two logic result signals enter and are passed on as outputs
// [R02] current output states readable for supervisory reporting
// [R03] rising edge gives an on event, falling edge an off event
// [R04] per-output on/off selects decide which events are stored; others dropped
// [R05] each stored event carries the time stamp of its change
// [R06] thirty-two inputs set only by control commands
// [R07] commands accepted from local virtual switch and supervisory host
// [R08] input states clear to zero on every restart
// [R09] each input runs in hold mode or pulse mode
// [R10] hold mode: set on command one, stays until command zero or restart
// [R11] pulse mode: set on command one, clears itself 5 ms later
// [R12] pulse timed by prescaled counter; repeat command restarts the count
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "lsb_defines.vh"
module lsb_bank #(
  parameter PRESCALE     = `LSB_PRESCALE,
  parameter PULSE_TICKS  = `LSB_PULSE_TICKS
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // user logic results, same clock domain
  input  wire [31:0] logic_result,
  // local virtual switch commands, one-cycle strobes
  input  wire [31:0] local_set,
  input  wire [31:0] local_clr,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // signal outputs
  output reg  [31:0] user_logic_out,
  output reg  [31:0] remote_ctrl_in,
  // event stream to the main event buffer
  output reg         ev_valid,
  output reg  [5:0]  ev_data,
  output reg  [31:0] ev_time,
  // interrupt
  output reg         irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [31:0] in_mode_reg;
  reg  [31:0] ev_on_sel_reg;
  reg  [31:0] ev_off_sel_reg;
  reg  [31:0] irq_stat_reg;
  reg  [31:0] irq_mask_reg;
  reg  [31:0] time_reg;
  reg  [31:0] prev_out_reg;
  reg  [31:0] on_pend_reg;
  reg  [31:0] off_pend_reg;
  reg  [31:0] stamp_reg [0:31];
  reg  [31:0] on_pend_next;
  reg  [31:0] off_pend_next;
  reg  [31:0] in_next;
  reg  [31:0] cmd_set;
  reg  [31:0] cmd_clr;
  reg         pick_found;
  reg  [4:0]  pick_idx;
  reg         pick_on;
  reg         overrun;
  wire        tick;
  wire [31:0] expire;
  wire [31:0] rise;
  wire [31:0] fall;
  integer     i;
  integer     j;
  integer     k;

  function is_addr;
    input [7:0] a;
    input [7:0] target;
    begin
      is_addr = (a == target);
    end
  endfunction

  // ----------------------------------------------------------------
  // time base and pulse timers
  // ----------------------------------------------------------------
  lsb_prescaler #(
    .DIV(PRESCALE)
  ) u_presc (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  ); // [R12]

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_pulse
      lsb_pulse_timer #(
        .TICKS(PULSE_TICKS)
      ) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (cmd_set[g] & in_mode_reg[g]),
        .tick   (tick),
        .expire (expire[g])
      ); // [R11] [R12]
    end
  endgenerate

  // free running microsecond time stamp
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_reg <= `LSB_RST_ZERO;
    end else if (tick) begin
      time_reg <= time_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // commands from both sources
  // ----------------------------------------------------------------
  always @* begin
    cmd_set = local_set; // [R07]
    cmd_clr = local_clr;
    if (reg_wr && is_addr(reg_addr, `LSB_ADDR_CMD_SET)) begin
      cmd_set = cmd_set | reg_wdata; // [R07]
    end
    if (reg_wr && is_addr(reg_addr, `LSB_ADDR_CMD_CLR)) begin
      cmd_clr = cmd_clr | reg_wdata;
    end
  end

  always @* begin
    for (j = 0; j < 32; j = j + 1) begin
      if (cmd_set[j]) begin
        in_next[j] = 1'b1; // [R10] [R11]
      end else if (!in_mode_reg[j] && cmd_clr[j]) begin
        in_next[j] = 1'b0; // [R10]
      end else if (in_mode_reg[j] && expire[j]) begin
        in_next[j] = 1'b0; // [R11]
      end else begin
        in_next[j] = remote_ctrl_in[j];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_ctrl_in <= `LSB_RST_ZERO; // [R08]
    end else begin
      remote_ctrl_in <= in_next; // [R06] [R09]
    end
  end

  // ----------------------------------------------------------------
  // logic outputs and event detection
  // ----------------------------------------------------------------
  assign rise = logic_result & ~prev_out_reg;
  assign fall = ~logic_result & prev_out_reg;

  always @* begin
    pick_found = 1'b0;
    pick_idx   = 5'h00;
    pick_on    = 1'b0;
    for (k = 31; k >= 0; k = k - 1) begin
      if (on_pend_reg[k] || off_pend_reg[k]) begin
        pick_found = 1'b1;
        pick_idx   = k[4:0];
        pick_on    = on_pend_reg[k];
      end
    end
    on_pend_next  = on_pend_reg;
    off_pend_next = off_pend_reg;
    if (pick_found) begin
      if (pick_on) begin
        on_pend_next[pick_idx] = 1'b0;
      end else begin
        off_pend_next[pick_idx] = 1'b0;
      end
    end
    // new edges win over the drain of the same slot
    on_pend_next  = on_pend_next | (rise & ev_on_sel_reg); // [R03] [R04]
    off_pend_next = off_pend_next | (fall & ev_off_sel_reg); // [R03] [R04]
    // a second change before the first drains is an overrun
    overrun = |(((rise & ev_on_sel_reg) | (fall & ev_off_sel_reg))
                & (on_pend_reg | off_pend_reg));
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_out_reg   <= `LSB_RST_ZERO;
      user_logic_out <= `LSB_RST_ZERO;
      on_pend_reg    <= `LSB_RST_ZERO;
      off_pend_reg   <= `LSB_RST_ZERO;
      ev_valid       <= 1'b0;
      ev_data        <= 6'h00;
      ev_time        <= `LSB_RST_ZERO;
    end else begin
      prev_out_reg   <= logic_result;
      user_logic_out <= logic_result; // [R01]
      on_pend_reg    <= on_pend_next;
      off_pend_reg   <= off_pend_next;
      ev_valid       <= pick_found;
      // the last event word stays readable between pulses
      ev_data        <= pick_found ? {pick_on, pick_idx} : ev_data; // [R03]
      ev_time        <= pick_found ? stamp_reg[pick_idx] : ev_time; // [R05]
    end
  end

  // stamps are caught at the change, not when the event drains
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 32; i = i + 1) begin
        stamp_reg[i] <= `LSB_RST_ZERO;
      end
    end else begin
      for (i = 0; i < 32; i = i + 1) begin
        if ((rise[i] & ev_on_sel_reg[i]) | (fall[i] & ev_off_sel_reg[i])) begin
          stamp_reg[i] <= time_reg; // [R05]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes and interrupt status
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_mode_reg    <= `LSB_RST_ZERO;
      ev_on_sel_reg  <= `LSB_RST_EV_SEL;
      ev_off_sel_reg <= `LSB_RST_EV_SEL;
      irq_mask_reg   <= `LSB_RST_ZERO;
    end else if (reg_wr) begin
      if (is_addr(reg_addr, `LSB_ADDR_IN_MODE)) begin
        in_mode_reg <= reg_wdata; // [R09]
      end
      if (is_addr(reg_addr, `LSB_ADDR_EV_ON_SEL)) begin
        ev_on_sel_reg <= reg_wdata; // [R04]
      end
      if (is_addr(reg_addr, `LSB_ADDR_EV_OFF_SEL)) begin
        ev_off_sel_reg <= reg_wdata; // [R04]
      end
      if (is_addr(reg_addr, `LSB_ADDR_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata;
      end
    end
  end

  // read clears, but a new event in the same cycle wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= `LSB_RST_ZERO;
    end else begin
      irq_stat_reg <= ((reg_rd && is_addr(reg_addr, `LSB_ADDR_IRQ_STAT))
                       ? `LSB_RST_ZERO : irq_stat_reg)
                      | {30'h0, overrun, pick_found};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `LSB_RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `LSB_ADDR_OUT_STATE:  reg_rdata <= user_logic_out; // [R02]
        `LSB_ADDR_IN_STATE:   reg_rdata <= remote_ctrl_in;
        `LSB_ADDR_IN_MODE:    reg_rdata <= in_mode_reg;
        `LSB_ADDR_EV_ON_SEL:  reg_rdata <= ev_on_sel_reg;
        `LSB_ADDR_EV_OFF_SEL: reg_rdata <= ev_off_sel_reg;
        `LSB_ADDR_IRQ_STAT:   reg_rdata <= irq_stat_reg;
        `LSB_ADDR_IRQ_MASK:   reg_rdata <= irq_mask_reg;
        `LSB_ADDR_TIME_LO:    reg_rdata <= time_reg;
        `LSB_ADDR_EV_DATA:    reg_rdata <= {26'h0, ev_data};
        `LSB_ADDR_EV_TIME:    reg_rdata <= ev_time;
        default:              reg_rdata <= `LSB_RST_ZERO;
      endcase
    end else begin
      reg_rdata <= `LSB_RST_ZERO;
    end
  end
endmodule // lsb_bank

// >>> bench/lsb_bank_asserts.sv
// checker for the logical signal bank ports
`timescale 1ns/1ps
module lsb_bank_chk (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // watched ports
  input wire [31:0] logic_result,
  input wire [31:0] local_set,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_rdata,
  input wire [31:0] user_logic_out,
  input wire [31:0] remote_ctrl_in,
  input wire        ev_valid,
  input wire [5:0]  ev_data,
  input wire [31:0] ev_time,
  input wire        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---
  // port relations
  // ---
  a_out_follows: assert property ($past(rst_n) |-> user_logic_out == $past(logic_result))
    else $error("output bank not one cycle behind");
  a_rd_out_state: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(user_logic_out))
    else $error("output state read wrong");
  a_rd_in_state: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rdata == $past(remote_ctrl_in))
    else $error("input state read wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_set_visible: assert property (
    |local_set |=> (remote_ctrl_in & $past(local_set)) == $past(local_set))
    else $error("command one not taken");
  a_no_free_rise: assert property ($past(rst_n) && !$past(reg_wr) |->
    (remote_ctrl_in & ~$past(remote_ctrl_in) & ~$past(local_set)) == 32'h0)
    else $error("input rose without command");
  a_restart_zero: assert property (!$past(rst_n) |->
    remote_ctrl_in == 32'h0 && !ev_valid && !irq)
    else $error("state left after restart");
  a_event_holds: assert property ($past(rst_n) && !ev_valid |->
    $stable(ev_time) && $stable(ev_data))
    else $error("event word moved without event");
endmodule // lsb_bank_chk

bind lsb_bank lsb_bank_chk chk_u (.clk(clk), .rst_n(rst_n), .logic_result(logic_result),
  .local_set(local_set), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .user_logic_out(user_logic_out), .remote_ctrl_in(remote_ctrl_in),
  .ev_valid(ev_valid), .ev_data(ev_data), .ev_time(ev_time), .irq(irq));

// >>> bench/lsb_logic_model.sv
// user logic model feeding the output bank
`timescale 1ns/1ps
module lsb_logic_model (
  // clock
  input  wire        clk,
  // wished and driven results
  input  wire [31:0] want,
  output reg  [31:0] logic_result
);
  // ---
  // results land one cycle late, like a logic scan
  // ---
  initial logic_result = 32'h0;
  always @(posedge clk) logic_result <= want;
endmodule // lsb_logic_model

// >>> bench/lsb_bank_test.sv
// self-checking bench for the logical signal bank
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module lsb_bank_test;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_q = 0, irq, ev_valid;
  logic [31:0] want = 0, lr, local_set = 0, local_clr = 0, reg_wdata = 0;
  logic [31:0] reg_rdata, ulo, rci, ev_time, ons, offs;
  logic [7:0]  reg_addr = 0;
  logic [5:0]  ev_data;
  logic [31:0] rq[$], exp_r;
  logic [5:0]  exp_e;
  logic [5:0]  eq[$];
  int          fail_count = 0, compares = 0, i, n_ev = 0;
  // ---
  // structure
  // ---
  lsb_logic_model lm_u (.clk(clk), .want(want), .logic_result(lr));
  lsb_bank #(.PRESCALE(2), .PULSE_TICKS(5)) dut_u (.clk(clk), .rst_n(rst_n),
    .logic_result(lr), .local_set(local_set), .local_clr(local_clr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .user_logic_out(ulo), .remote_ctrl_in(rci), .ev_valid(ev_valid), .ev_data(ev_data),
    .ev_time(ev_time), .irq(irq));
  initial forever #25 clk = ~clk;
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 0;
  endtask
  task cmd(input [31:0] s, input [31:0] c);
    @(posedge clk);
    local_set <= s;
    local_clr <= c;
    @(posedge clk);
    local_set <= 0;
    local_clr <= 0;
  endtask
  // spaced flips keep one event pending at most, so no overrun
  task flip(input int b);
    @(posedge clk);
    want[b] <= !want[b];
    if (want[b] ? offs[b] : ons[b]) begin
      eq.push_back({!want[b], b[4:0]});
      n_ev++;
    end
    cyc(6);
  endtask
  task give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_q <= reg_rd;
    // pop once: the macro names its expected value twice
    if (rd_q) begin
      exp_r = rq.pop_front();
      `CHK(reg_rdata, exp_r)
    end
    if (ev_valid) begin
      exp_e = eq.pop_front();
      `CHK(ev_data, exp_e)
    end
  end
  initial begin
    void'($urandom(32'h8bba13f1));
    ons = 32'hffff_ffff;
    offs = 32'hffff_ffff;
    cyc(2);
    rst_n <= 1;
    rd(8'h08, 32'h0);
    rd(8'h14, 32'hffff_ffff);
    rd(8'h18, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h3c, 32'h0);
    flip(0);
    `CHK(irq, 1'b0)
    rd(8'h28, 32'h20);
    wr(8'h20, 32'h1);
    cyc(3);
    `CHK(irq, 1'b1)
    rd(8'h1c, 32'h1);
    cyc(3);
    `CHK(irq, 1'b0)
    ons = $urandom;
    offs = $urandom;
    wr(8'h14, ons);
    wr(8'h18, offs);
    for (i = 0; i < 8; i++) flip($urandom_range(31));
    rd(8'h00, want);
    `CHK(irq, n_ev > 1)
    wr(8'h08, 32'h20);
    cmd(32'h20, 32'h0);
    cyc(5);
    `CHK(rci[5], 1'b1)
    cmd(32'h20, 32'h20);
    cyc(8);
    `CHK(rci[5], 1'b1)
    cyc(8);
    `CHK(rci[5], 1'b0)
    cmd(32'h1, 32'h0);
    cyc(20);
    `CHK(rci[0], 1'b1)
    wr(8'h10, 32'h1);
    cyc(1);
    `CHK(rci[0], 1'b0)
    wr(8'h0c, 32'h2);
    cyc(1);
    `CHK(rci[1], 1'b1)
    rst_n <= 0;
    cyc(2);
    // after restart the held results look like fresh rises, lowest index first
    for (i = 0; i < 32; i++) if (want[i]) eq.push_back({1'b1, i[4:0]});
    rst_n <= 1;
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    for (i = 0; i < 50 && eq.size() != 0; i++) cyc(1);
    if (eq.size() != 0) fail_count++;
    cyc(2);
    give_verdict;
  end
  initial begin
    cyc(5000);
    fail_count++;
    give_verdict;
  end
endmodule // lsb_bank_test
